// [shared/rrs_pkg.sv]
// Package for the regulator reset sequencer: timing figures and state codes.
// Assumes a 40 MHz reference clock that runs whenever the device is powered.
package rrs_pkg;
    localparam int unsigned CLOCK_HZ         = 40000000;
    // Longest power-on hold and host settling figures, in milliseconds
    localparam int unsigned POR_HOLD_MS      = 110;
    localparam int unsigned ACCESS_WAIT_MS   = 150;
    localparam int unsigned DISCHARGE_MS     = 10;
    // Pin synchroniser and output register add this many cycles to the hold
    localparam int unsigned SYNC_LATENCY     = 5;
    // Longest time rounds down, least time rounds up; the hold gives up the latency
    localparam longint unsigned POR_HOLD_CYCLES    = (64'(CLOCK_HZ) * POR_HOLD_MS) / 1000 - SYNC_LATENCY;
    localparam longint unsigned ACCESS_WAIT_CYCLES = (64'(CLOCK_HZ) * ACCESS_WAIT_MS + 999) / 1000;
    localparam longint unsigned DISCHARGE_CYCLES   = (64'(CLOCK_HZ) * DISCHARGE_MS + 999) / 1000;
    localparam int unsigned COUNT_WIDTH      = 32;
    localparam logic [2:0] SYNC_RESET        = 3'h0;

    typedef enum logic [1:0] {
        RRS_WAIT_SUPPLY = 2'h0,
        RRS_POR_HOLD    = 2'h1,
        RRS_RUN         = 2'h2
    } rrs_state_t;
endpackage : rrs_pkg

// [rtl/rrs_pin_sync.sv]
// Three-stage synchroniser with agreement filter for one asynchronous pin.
// Assumes the pin is a slow level; the output moves once stages one and two agree.
`timescale 1ns/1ps
module rrs_pin_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Pin and filtered level
    input  wire logic pin,
    output logic      level
);
    import rrs_pkg::*;

    logic [2:0] stage_reg;
    logic       level_reg;
    wire        agree = (stage_reg[1] == stage_reg[2]);

    always_ff @(posedge clock) begin
        if (reset) begin
            stage_reg <= SYNC_RESET;
            level_reg <= 1'b0;
        end else begin
            // Stage zero is read only by stage one
            stage_reg <= {stage_reg[1:0], pin};
            if (agree) begin
                level_reg <= stage_reg[2];
            end
        end
    end

    assign level = level_reg;
endmodule : rrs_pin_sync

// [rtl/rrs_sequencer.sv]
// Regulator and reset sequencer for a combined LAN and short-range-radio device.
// Assumes the host drives both power requests as slow levels and that the
// supply-valid indications come from analogue comparators, all asynchronous.
// Summary of operation
// - LAN request high: regulators on, LAN released once the power-on hold ends
// - LAN request low: LAN section held reset
// - Regulator enable is OR of requests
// - Radio request low: radio section held reset
// - Power-on reset releases within 110 ms
// - Longer host delays are always tolerated
`timescale 1ns/1ps
module rrs_sequencer #(
    parameter longint unsigned POR_CYCLES = rrs_pkg::POR_HOLD_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Host power requests
    input  wire logic lan_power_request,
    input  wire logic radio_power_request,
    // Supply-valid indications
    input  wire logic core_supply_valid,
    input  wire logic io_supply_valid,
    // Regulator and section controls
    output logic      regulator_enable,
    output logic      power_on_reset,
    output logic      lan_reset,
    output logic      radio_reset
);
    import rrs_pkg::*;

    // The counter and the release bound must both fit the count width
    if (POR_CYCLES < 1 || POR_CYCLES > 64'hFFFFFFFF - SYNC_LATENCY) begin : g_por_range
        $error("POR_CYCLES out of range");
    end


    logic lan_req;
    logic radio_req;
    logic core_ok;
    logic io_ok;

    rrs_pin_sync u_sync_lan (.clock(clock), .reset(reset), .pin(lan_power_request), .level(lan_req));
    rrs_pin_sync u_sync_radio (.clock(clock), .reset(reset), .pin(radio_power_request), .level(radio_req));
    rrs_pin_sync u_sync_core (.clock(clock), .reset(reset), .pin(core_supply_valid), .level(core_ok));
    rrs_pin_sync u_sync_io (.clock(clock), .reset(reset), .pin(io_supply_valid), .level(io_ok));

    rrs_state_t             state_reg;
    rrs_state_t             state_next;
    logic [COUNT_WIDTH-1:0] count_reg;
    logic [COUNT_WIDTH-1:0] count_next;
    logic                   regulator_enable_reg;
    logic                   power_on_reset_reg;
    logic                   lan_reset_reg;
    logic                   radio_reset_reg;

    localparam logic [COUNT_WIDTH-1:0] POR_LAST = COUNT_WIDTH'(POR_CYCLES - 1);
    // Pin synchroniser and output register add a fixed latency to the hold
    localparam logic [COUNT_WIDTH-1:0] RELEASE_BOUND = COUNT_WIDTH'(POR_CYCLES + SYNC_LATENCY);

    // A section is held while the power-on hold runs or its own request is low
    function automatic logic section_hold(input logic por, input logic request);
        return por | ~request;
    endfunction : section_hold

    wire supplies_ok = core_ok & io_ok;
    wire hold_done   = (count_reg == POR_LAST);
    wire por_active  = (state_next != RRS_RUN);
    wire any_request = lan_req | radio_req;
    // Sections only leave reset once the power-on hold has ended
    wire lan_hold    = section_hold(por_active, lan_req);
    wire radio_hold  = section_hold(por_active, radio_req);

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            RRS_WAIT_SUPPLY: begin
                count_next = '0;
                if (supplies_ok) begin
                    state_next = RRS_POR_HOLD;
                end
            end
            RRS_POR_HOLD: begin
                // Counting the free-running reference clock bounds the hold
                if (!supplies_ok) begin
                    state_next = RRS_WAIT_SUPPLY;
                    count_next = '0;
                end else if (hold_done) begin
                    state_next = RRS_RUN;
                end else begin
                    count_next = count_reg + 1'b1;
                end
            end
            RRS_RUN: begin
                // No upper bound on idle time: any longer host delay is fine
                if (!supplies_ok) begin
                    state_next = RRS_WAIT_SUPPLY;
                end
            end
            default: begin
                state_next = RRS_WAIT_SUPPLY;
                count_next = '0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg            <= RRS_WAIT_SUPPLY;
            count_reg            <= '0;
            regulator_enable_reg <= 1'b0;
            power_on_reset_reg   <= 1'b1;
            lan_reset_reg        <= 1'b1;
            radio_reset_reg      <= 1'b1;
        end else begin
            state_reg            <= state_next;
            count_reg            <= count_next;
            regulator_enable_reg <= any_request;
            power_on_reset_reg   <= por_active;
            lan_reset_reg        <= lan_hold;
            radio_reset_reg      <= radio_hold;
        end
    end

    assign regulator_enable = regulator_enable_reg;
    assign power_on_reset   = power_on_reset_reg;
    assign lan_reset        = lan_reset_reg;
    assign radio_reset      = radio_reset_reg;

    // Helper: cycles spent in the hold state
    logic [COUNT_WIDTH-1:0] hold_age_reg;
    always_ff @(posedge clock) begin
        if (reset || state_reg != RRS_POR_HOLD) begin
            hold_age_reg <= '0;
        end else begin
            hold_age_reg <= hold_age_reg + 1'b1;
        end
    end

    chk_lan_release: assert property (@(posedge clock) disable iff (reset)
        (lan_req && state_next == RRS_RUN) |=> !lan_reset)
        else $error("LAN section not released while requested");

    chk_lan_hold: assert property (@(posedge clock) disable iff (reset)
        !lan_req |=> lan_reset)
        else $error("LAN section out of reset without request");

    chk_regulator_or: assert property (@(posedge clock) disable iff (reset)
        ##1 (regulator_enable == ($past(lan_req) | $past(radio_req))))
        else $error("Regulator enable is not the OR of requests");

    chk_regulator_off: assert property (@(posedge clock) disable iff (reset)
        (!lan_req && !radio_req)[*2] |-> !regulator_enable)
        else $error("Regulators on with both requests low");

    chk_radio_hold: assert property (@(posedge clock) disable iff (reset)
        (lan_req && !radio_req) |=> radio_reset)
        else $error("Radio section out of reset without request");

    chk_hold_bound: assert property (@(posedge clock) disable iff (reset)
        state_reg == RRS_POR_HOLD |-> hold_age_reg < COUNT_WIDTH'(POR_CYCLES))
        else $error("Power-on hold too long");

    chk_por_release: assert property (@(posedge clock) disable iff (reset)
        $fell(power_on_reset) |-> $past(hold_age_reg) == POR_LAST)
        else $error("Power-on reset released at wrong count");

    chk_por_supply: assert property (@(posedge clock) disable iff (reset)
        !supplies_ok |=> power_on_reset && lan_reset && radio_reset)
        else $error("Reset released without valid supplies");

    chk_run_stays: assert property (@(posedge clock) disable iff (reset)
        (state_reg == RRS_RUN && supplies_ok) |=> state_reg == RRS_RUN)
        else $error("Left run state with supplies valid");

    chk_radio_release: assert property (@(posedge clock) disable iff (reset)
        (radio_req && state_next == RRS_RUN) |=> !radio_reset)
        else $error("Radio section not released while requested");

    chk_radio_low: assert property (@(posedge clock) disable iff (reset)
        !radio_req |=> radio_reset)
        else $error("Radio section out of reset with request low");

    chk_lan_regulator: assert property (@(posedge clock) disable iff (reset)
        lan_req |=> regulator_enable)
        else $error("Regulators off while LAN requested");

    chk_regulator_on: assert property (@(posedge clock) disable iff (reset)
        radio_req |=> regulator_enable)
        else $error("Regulators off while radio requested");

    chk_sections_por: assert property (@(posedge clock) disable iff (reset)
        power_on_reset |-> lan_reset && radio_reset)
        else $error("Section out of reset during power-on hold");

    chk_wait_por: assert property (@(posedge clock) disable iff (reset)
        state_reg == RRS_WAIT_SUPPLY |-> power_on_reset)
        else $error("Power-on reset low while waiting for supplies");

    chk_count_start: assert property (@(posedge clock) disable iff (reset)
        (state_reg == RRS_WAIT_SUPPLY && supplies_ok) |=> state_reg == RRS_POR_HOLD && count_reg == '0)
        else $error("Hold did not start from zero");

    chk_count_age: assert property (@(posedge clock) disable iff (reset)
        state_reg == RRS_POR_HOLD |-> count_reg == hold_age_reg)
        else $error("Hold count lost step with elapsed cycles");

    // Helper: cycles since both supply pins read valid, saturating at the release bound
    logic [COUNT_WIDTH-1:0] since_valid_reg;
    always_ff @(posedge clock) begin
        if (reset || !(core_supply_valid && io_supply_valid)) begin
            since_valid_reg <= '0;
        end else if (since_valid_reg != RELEASE_BOUND) begin
            since_valid_reg <= since_valid_reg + 1'b1;
        end
    end

    chk_release_bound: assert property (@(posedge clock) disable iff (reset)
        since_valid_reg == RELEASE_BOUND |-> !power_on_reset)
        else $error("Power-on reset held past the bound");
endmodule : rrs_sequencer

// [dv/rrs_host_model.sv]
// Host model: drives both power request pins from the levels the bench wants.
// Assumes the bench sets want_lan and want_radio at will; the model delays any raise that follows both requests low.
`timescale 1ns/1ps
module rrs_host_model #(
    parameter int DISCHARGE   = 8,
    parameter int ACCESS_WAIT = 34
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Wanted levels and supply state
    input  wire logic want_lan,
    input  wire logic want_radio,
    input  wire logic supplies_up,
    // Request pins and bus access permission
    output logic      lan_power_request,
    output logic      radio_power_request,
    output logic      access_open
);
    int idle_cnt;
    int up_cnt;
    // No bus access until the supplies have been up for the access wait
    always @(negedge clock) begin
        if (reset || !supplies_up) begin
            up_cnt      <= 0;
            access_open <= 1'h0;
        end else if (up_cnt < ACCESS_WAIT) begin
            up_cnt <= up_cnt + 1;
        end else begin
            access_open <= 1'h1;
        end
    end
    // Both low: wait out the discharge before any raise, an early raise risks in-rush
    always @(negedge clock) begin
        if (reset) begin
            lan_power_request   <= 1'h0;
            radio_power_request <= 1'h0;
            idle_cnt            <= 0;
        end else if (!lan_power_request && !radio_power_request && idle_cnt < DISCHARGE) begin
            idle_cnt <= idle_cnt + 1;
        end else begin
            lan_power_request   <= want_lan;
            radio_power_request <= want_radio;
            idle_cnt            <= 0;
        end
    end
endmodule : rrs_host_model

// [dv/test_rrs_sequencer.sv]
// Testbench for the regulator reset sequencer with a host model on the request pins.
// Assumes a shortened power-on hold of 20 cycles.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0b seen %0b", nm, exp, got); end end
module test_rrs_sequencer;
    import rrs_pkg::*;
    localparam int POR = 20;
    logic clock, reset, want_lan, want_radio, core_supply_valid, io_supply_valid;
    logic lan_power_request, radio_power_request, access_open;
    logic regulator_enable, power_on_reset, lan_reset, radio_reset;
    logic [1:0] seq [5] = '{2'h3, 2'h2, 2'h0, 2'h1, 2'h3};
    int n_mismatch = 0;
    int n_tests = 0;
    int took;
    rrs_host_model rrs_host_model_i (.clock(clock), .reset(reset), .want_lan(want_lan),
        .want_radio(want_radio), .lan_power_request(lan_power_request),
        .radio_power_request(radio_power_request), .supplies_up(core_supply_valid & io_supply_valid),
        .access_open(access_open));
    rrs_sequencer #(.POR_CYCLES(POR)) rrs_sequencer_i (.clock(clock), .reset(reset),
        .lan_power_request(lan_power_request), .radio_power_request(radio_power_request),
        .core_supply_valid(core_supply_valid), .io_supply_valid(io_supply_valid),
        .regulator_enable(regulator_enable), .power_on_reset(power_on_reset),
        .lan_reset(lan_reset), .radio_reset(radio_reset));
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // Bounded wait for the power-on reset level; a hang ends the run
    task automatic wait_por(input logic lvl, input int bound);
        took = 0;
        while (power_on_reset !== lvl && took < bound) begin
            @(negedge clock);
            took++;
        end
        if (power_on_reset !== lvl) begin
            n_mismatch++;
            $display("CHECK FAILED por wait expected %0b seen %0b", lvl, power_on_reset);
            print_verdict();
        end
    endtask : wait_por
    task automatic test_power_up();
        core_supply_valid = 1'h1;
        io_supply_valid   = 1'h1;
        wait_por(1'h0, 60);
        `CHK("hold not short", 1'h1, took >= POR + 3)
        `CHK("hold not long", 1'h1, took <= POR + 7)
        repeat (2) @(negedge clock);
        `CHK("lan released", 1'h0, lan_reset)
        while (!access_open && took < 60) begin
            @(negedge clock);
            took++;
        end
        `CHK("released before access", 2'h2, {access_open, power_on_reset})
        $display("test_power_up done");
    endtask : test_power_up
    task automatic test_modes();
        foreach (seq[i]) begin
            want_lan   = seq[i][1];
            want_radio = seq[i][0];
            repeat (30) @(negedge clock);
            `CHK("regulator or", seq[i][1] | seq[i][0], regulator_enable)
            `CHK("lan reset", ~seq[i][1], lan_reset)
            `CHK("radio reset", ~seq[i][0], radio_reset)
        end
        $display("test_modes done");
    endtask : test_modes
    task automatic test_supply_loss();
        io_supply_valid = 1'h0;
        repeat (10) @(negedge clock);
        `CHK("por on loss", 1'h1, power_on_reset)
        `CHK("lan held on loss", 1'h1, lan_reset)
        io_supply_valid = 1'h1;
        repeat (POR) @(negedge clock);
        `CHK("count restarted", 1'h1, power_on_reset)
        wait_por(1'h0, 30);
        repeat (2) @(negedge clock);
        `CHK("lan back", 1'h0, lan_reset)
        $display("test_supply_loss done");
    endtask : test_supply_loss
    initial begin
        reset = 1'h1;
        want_lan = 1'h1;
        want_radio = 1'h1;
        core_supply_valid = 1'h0;
        io_supply_valid = 1'h0;
        repeat (8) @(negedge clock);
        reset <= 1'h0;
        repeat (4) @(negedge clock);
        `CHK("por before supply", 1'h1, power_on_reset)
        test_power_up();
        test_modes();
        test_supply_loss();
        print_verdict();
    end
endmodule : test_rrs_sequencer
